//--- rtl/mcu_sfr_pkg.sv
// register map, field positions, reset values and op codes of the core register bank
package mcu_sfr_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] DPL_ADDR = 8'h82;
  localparam logic [7:0] DPH_ADDR = 8'h83;
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] EXT_PORT_CONFIG_ADDR = 8'h9f;
  localparam logic [7:0] CFG_ADDR = 8'haf;
  localparam logic [7:0] PSW_ADDR = 8'hd0;
  localparam logic [7:0] ACC_ADDR = 8'he0;
  localparam logic [7:0] B_ADDR = 8'hf0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] POINTER_PAIR_RESET = 16'h0000;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] EXT_PORT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h81;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] B_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PSW_CARRY = 7;
  localparam int PSW_HALF_CARRY = 6;
  localparam int PSW_USER_HIGH = 5;
  localparam int PSW_BANK_MSB = 4;
  localparam int PSW_BANK_LSB = 3;
  localparam int PSW_OVERFLOW = 2;
  localparam int PSW_USER_LOW = 1;
  localparam int PSW_PARITY = 0;
  localparam int POWER_CONTROL_BAUD = 7;
  localparam int CFG_ERR_CHECK = 6;
  localparam int CFG_SYNC_PORT = 5;
  localparam int CFG_CARRIER = 4;
  localparam int CFG_XRAM_MSB = 1;
  localparam int CFG_XRAM_LSB = 0;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int BANK_BYTES = 8;
  localparam int XRAM_BYTES = 256;

  typedef enum logic [2:0] {
    ALU_NONE = 3'b000,
    ALU_ADD = 3'b001,
    ALU_ADDC = 3'b010,
    ALU_SUBB = 3'b011,
    ALU_MUL = 3'b100,
    ALU_DIV = 3'b101
  } alu_op_t;

endpackage : mcu_sfr_pkg

//--- rtl/flag_if.sv
// carrier between the register bank and its flag-update decoder
`timescale 1ns/1ps
interface flag_if;
  mcu_sfr_pkg::alu_op_t op;
  logic carry_we;
  logic half_carry_we;
  logic overflow_we;
  modport bank (output op, input carry_we, input half_carry_we, input overflow_we);
  modport unit (input op, output carry_we, output half_carry_we, output overflow_we);
endinterface : flag_if

//--- rtl/psw_flag_unit.sv
// decodes which status flags an arithmetic operation updates
`timescale 1ns/1ps
module psw_flag_unit (
  flag_if.unit fl
);
  always_comb begin
    fl.carry_we = 1'b0;
    fl.half_carry_we = 1'b0;
    fl.overflow_we = 1'b0;
    unique case (fl.op)
      mcu_sfr_pkg::ALU_NONE: begin
      end
      mcu_sfr_pkg::ALU_ADD, mcu_sfr_pkg::ALU_ADDC: begin
        fl.carry_we = 1'b1;
        fl.half_carry_we = 1'b1;
        fl.overflow_we = 1'b1;
      end
      mcu_sfr_pkg::ALU_SUBB, mcu_sfr_pkg::ALU_MUL, mcu_sfr_pkg::ALU_DIV: begin
        fl.carry_we = 1'b1;
        fl.overflow_we = 1'b1;
      end
      // codes 110 and 111 are unused and touch no flag
      default: begin
      end
    endcase
  end
endmodule : psw_flag_unit

//--- rtl/even_parity.sv
// even-parity bit for one byte
`timescale 1ns/1ps
module even_parity (
  input wire logic [7:0] i_data,
  output logic o_parity
);
  // set when the byte holds an odd count of ones, so byte plus bit is even
  assign o_parity = ^i_data;
endmodule : even_parity

//--- rtl/mcu_core_sfr_bank.sv
// core special-function register bank: working, status, pointer and configuration registers
`timescale 1ns/1ps

module mcu_core_sfr_bank #(
  parameter int BANK_BYTES = mcu_sfr_pkg::BANK_BYTES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_bit_rd,
  input wire logic i_bit_wdata,
  input wire mcu_sfr_pkg::alu_op_t i_alu_op,
  input wire logic i_alu_carry,
  input wire logic i_alu_half_carry,
  input wire logic i_alu_overflow,
  input wire logic i_acc_load,
  input wire logic [7:0] i_acc_data,
  input wire logic i_b_load,
  input wire logic [7:0] i_b_data,
  input wire logic i_pointer_pair_load,
  input wire logic [15:0] i_pointer_pair_data,
  input wire logic i_pointer_pair_inc,
  input wire logic i_sp_inc,
  input wire logic i_sp_dec,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic o_bit_rdata,
  output logic o_bit_hit,
  output logic [7:0] o_acc,
  output logic [7:0] o_b,
  output logic [7:0] o_psw,
  output logic [15:0] o_pointer_pair,
  output logic [7:0] o_sp,
  output logic [4:0] o_bank_base,
  output logic o_baud_doubler,
  output logic o_uart_error_check_enable,
  output logic o_sync_port_select,
  output logic [7:0] o_carrier_pin_select,
  output logic o_xram_move_enable
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the bank base is a five-bit byte address into the low 32 bytes
  if (BANK_BYTES * 4 > 32 || (BANK_BYTES & (BANK_BYTES - 1)) != 0) begin : g_bad_bank
    $error("bank size must be a power of two with four banks inside 32 bytes");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic bit_hit(input logic [7:0] ba, input logic [7:0] base);
    bit_hit = (ba[7:3] == base[7:3]);
  endfunction : bit_hit

  function automatic logic [7:0] set_bit(input logic [7:0] val, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] r;
    r = val;
    r[idx] = b;
    set_bit = r;
  endfunction : set_bit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] acc_reg, acc_next;
  logic [7:0] b_reg, b_next;
  logic [7:0] psw_reg, psw_next, psw_sw;
  logic [7:0] dpl_reg, dpl_next;
  logic [7:0] dph_reg, dph_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] power_control_reg, power_control_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] ext_port_config_reg, ext_port_config_next;
  logic parity_next;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire wr_acc = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::ACC_ADDR);
  wire wr_b = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::B_ADDR);
  wire wr_psw = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::PSW_ADDR);
  wire wr_dpl = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::DPL_ADDR);
  wire wr_dph = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::DPH_ADDR);
  wire wr_sp = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::SP_ADDR);
  wire wr_power_control = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::POWER_CONTROL_ADDR);
  wire wr_cfg = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::CFG_ADDR);
  wire wr_ext_port_config = i_sfr_wr && (i_sfr_addr == mcu_sfr_pkg::EXT_PORT_CONFIG_ADDR);
  // only these three answer single-bit access
  wire bit_acc = bit_hit(i_bit_addr, mcu_sfr_pkg::ACC_ADDR);
  wire bit_b = bit_hit(i_bit_addr, mcu_sfr_pkg::B_ADDR);
  wire bit_psw = bit_hit(i_bit_addr, mcu_sfr_pkg::PSW_ADDR);
  wire bwr_acc = i_bit_wr && bit_acc;
  wire bwr_b = i_bit_wr && bit_b;
  wire bwr_psw = i_bit_wr && bit_psw;
  wire pointer_pair_sw = wr_dpl || wr_dph;

  // ----------------------------------------------------------------
  // flag decode
  // ----------------------------------------------------------------
  flag_if fl ();
  assign fl.op = i_alu_op;

  psw_flag_unit u_flags (
    .fl(fl.unit)
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // a direct write beats the datapath load in the same cycle
  assign acc_next = wr_acc ? i_sfr_wdata :
                    bwr_acc ? set_bit(acc_reg, i_bit_addr[2:0], i_bit_wdata) :
                    i_acc_load ? i_acc_data : acc_reg;
  assign b_next = wr_b ? i_sfr_wdata :
                  bwr_b ? set_bit(b_reg, i_bit_addr[2:0], i_bit_wdata) :
                  i_b_load ? i_b_data : b_reg;

  even_parity u_parity (
    .i_data(acc_next),
    .o_parity(parity_next)
  );

  // user flags and bank select change only through software writes
  assign psw_sw = wr_psw ? i_sfr_wdata :
                  bwr_psw ? set_bit(psw_reg, i_bit_addr[2:0], i_bit_wdata) : psw_reg;

  // arithmetic flag updates win over a software write in the same cycle
  always_comb begin
    psw_next = psw_sw;
    if (fl.carry_we) begin
      psw_next[mcu_sfr_pkg::PSW_CARRY] = i_alu_carry;
    end
    if (fl.half_carry_we) begin
      psw_next[mcu_sfr_pkg::PSW_HALF_CARRY] = i_alu_half_carry;
    end
    if (fl.overflow_we) begin
      psw_next[mcu_sfr_pkg::PSW_OVERFLOW] = i_alu_overflow;
    end
    // parity is hardware-owned; written values are dropped
    psw_next[mcu_sfr_pkg::PSW_PARITY] = parity_next;
  end

  // a byte write blocks a whole-pointer load or increment for that cycle
  wire [15:0] pointer_pair_hw = i_pointer_pair_load ? i_pointer_pair_data :
                        i_pointer_pair_inc ? {dph_reg, dpl_reg} + 16'h0001 : {dph_reg, dpl_reg};
  assign dpl_next = pointer_pair_sw ? (wr_dpl ? i_sfr_wdata : dpl_reg) : pointer_pair_hw[7:0];
  assign dph_next = pointer_pair_sw ? (wr_dph ? i_sfr_wdata : dph_reg) : pointer_pair_hw[15:8];

  // wraps within eight bits; the stack lives in the extended RAM page
  assign sp_next = wr_sp ? i_sfr_wdata :
                   i_sp_inc ? sp_reg + 8'h01 :
                   i_sp_dec ? sp_reg - 8'h01 : sp_reg;

  // reserved bits are stored and read back but steer nothing
  assign power_control_next = wr_power_control ? i_sfr_wdata : power_control_reg;
  assign cfg_next = wr_cfg ? i_sfr_wdata : cfg_reg;
  assign ext_port_config_next = wr_ext_port_config ? i_sfr_wdata : ext_port_config_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire rd_known = (i_sfr_addr == mcu_sfr_pkg::ACC_ADDR) || (i_sfr_addr == mcu_sfr_pkg::B_ADDR) ||
                  (i_sfr_addr == mcu_sfr_pkg::PSW_ADDR) || (i_sfr_addr == mcu_sfr_pkg::DPL_ADDR) ||
                  (i_sfr_addr == mcu_sfr_pkg::DPH_ADDR) || (i_sfr_addr == mcu_sfr_pkg::SP_ADDR) ||
                  (i_sfr_addr == mcu_sfr_pkg::POWER_CONTROL_ADDR) ||
                  (i_sfr_addr == mcu_sfr_pkg::CFG_ADDR) ||
                  (i_sfr_addr == mcu_sfr_pkg::EXT_PORT_CONFIG_ADDR);
  wire [7:0] rd_mux = (i_sfr_addr == mcu_sfr_pkg::ACC_ADDR) ? acc_reg :
                      (i_sfr_addr == mcu_sfr_pkg::B_ADDR) ? b_reg :
                      (i_sfr_addr == mcu_sfr_pkg::PSW_ADDR) ? psw_reg :
                      (i_sfr_addr == mcu_sfr_pkg::DPL_ADDR) ? dpl_reg :
                      (i_sfr_addr == mcu_sfr_pkg::DPH_ADDR) ? dph_reg :
                      (i_sfr_addr == mcu_sfr_pkg::SP_ADDR) ? sp_reg :
                      (i_sfr_addr == mcu_sfr_pkg::POWER_CONTROL_ADDR) ? power_control_reg :
                      (i_sfr_addr == mcu_sfr_pkg::CFG_ADDR) ? cfg_reg :
                      (i_sfr_addr == mcu_sfr_pkg::EXT_PORT_CONFIG_ADDR) ? ext_port_config_reg : 8'h00;
  wire bit_known = bit_acc || bit_b || bit_psw;
  wire [7:0] bit_byte = bit_acc ? acc_reg : bit_b ? b_reg : bit_psw ? psw_reg : 8'h00;
  wire bit_sel = bit_byte[i_bit_addr[2:0]];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_reg <= mcu_sfr_pkg::ACC_RESET;
      b_reg <= mcu_sfr_pkg::B_RESET;
      psw_reg <= mcu_sfr_pkg::PSW_RESET;
      sp_reg <= mcu_sfr_pkg::SP_RESET;
      dpl_reg <= mcu_sfr_pkg::POINTER_PAIR_RESET[7:0];
      dph_reg <= mcu_sfr_pkg::POINTER_PAIR_RESET[15:8];
    end else if (i_clk_en) begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      psw_reg <= psw_next;
      sp_reg <= sp_next;
      dpl_reg <= dpl_next;
      dph_reg <= dph_next;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      power_control_reg <= mcu_sfr_pkg::POWER_CONTROL_RESET;
      cfg_reg <= mcu_sfr_pkg::CFG_RESET;
      ext_port_config_reg <= mcu_sfr_pkg::EXT_PORT_CONFIG_RESET;
      o_bank_base <= 5'h00;
      o_carrier_pin_select <= 8'h00;
      o_xram_move_enable <= mcu_sfr_pkg::CFG_RESET[mcu_sfr_pkg::CFG_XRAM_LSB];
    end else if (i_clk_en) begin
      power_control_reg <= power_control_next;
      cfg_reg <= cfg_next;
      ext_port_config_reg <= ext_port_config_next;
      o_bank_base <= 5'(psw_next[mcu_sfr_pkg::PSW_BANK_MSB:mcu_sfr_pkg::PSW_BANK_LSB]
                        * BANK_BYTES);
      o_carrier_pin_select <= cfg_next[mcu_sfr_pkg::CFG_CARRIER] ? ext_port_config_next : 8'h00;
      o_xram_move_enable <= |cfg_next[mcu_sfr_pkg::CFG_XRAM_MSB:mcu_sfr_pkg::CFG_XRAM_LSB];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
      o_bit_rdata <= 1'b0;
      o_bit_hit <= 1'b0;
    end else if (i_clk_en) begin
      o_sfr_rdata <= i_sfr_rd ? rd_mux : 8'h00;
      o_sfr_hit <= i_sfr_rd && rd_known;
      o_bit_rdata <= i_bit_rd && bit_sel;
      o_bit_hit <= i_bit_rd && bit_known;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_acc = acc_reg;
  assign o_b = b_reg;
  assign o_psw = psw_reg;
  assign o_pointer_pair = {dph_reg, dpl_reg};
  assign o_sp = sp_reg;
  assign o_baud_doubler = power_control_reg[mcu_sfr_pkg::POWER_CONTROL_BAUD];
  assign o_uart_error_check_enable = cfg_reg[mcu_sfr_pkg::CFG_ERR_CHECK];
  assign o_sync_port_select = cfg_reg[mcu_sfr_pkg::CFG_SYNC_PORT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  wire psw_touch = wr_psw || bwr_psw;
  wire arith_cov = (i_alu_op == mcu_sfr_pkg::ALU_ADD) || (i_alu_op == mcu_sfr_pkg::ALU_ADDC) ||
                   (i_alu_op == mcu_sfr_pkg::ALU_SUBB) || (i_alu_op == mcu_sfr_pkg::ALU_MUL) ||
                   (i_alu_op == mcu_sfr_pkg::ALU_DIV);

  sequence s_low_write;
    i_clk_en && wr_dpl && !wr_dph;
  endsequence
  sequence s_high_write;
    i_clk_en && wr_dph && !wr_dpl;
  endsequence

  a_parity_even: assert property (^{acc_reg, psw_reg[0]} == 1'b0)
    else $error("parity bit does not make the working register even");
  a_carry_update: assert property (i_clk_en && arith_cov |=> psw_reg[7] == $past(i_alu_carry))
    else $error("carry flag not taken from the arithmetic result");
  a_half_carry_keep: assert property (i_clk_en && !psw_touch && (i_alu_op ==
    mcu_sfr_pkg::ALU_SUBB || i_alu_op == mcu_sfr_pkg::ALU_MUL) |=> $stable(psw_reg[6]))
    else $error("half carry changed by an operation that must leave it");
  a_overflow_update: assert property (i_clk_en && arith_cov
    |=> psw_reg[2] == $past(i_alu_overflow))
    else $error("overflow flag not taken from the arithmetic result");
  a_user_flags_keep: assert property (i_clk_en && !psw_touch
    |=> $stable(psw_reg[5]) && $stable(psw_reg[1]))
    else $error("user flag changed without a software write");
  a_bank_base_track: assert property (o_bank_base == 5'(psw_reg[4:3] * BANK_BYTES))
    else $error("bank base does not follow the bank select");
  a_pointer_pair_order: assert property (s_low_write ##1 s_high_write
    |=> o_pointer_pair == {$past(i_sfr_wdata), $past(i_sfr_wdata, 2)})
    else $error("pointer pair does not join high and low bytes");
  a_stack_write: assert property (i_clk_en && wr_sp |=> o_sp == $past(i_sfr_wdata))
    else $error("stack pointer did not take the written byte");
  a_byte_only_regs: assert property (i_clk_en && i_bit_wr && !i_sfr_wr && !i_sp_inc && !i_sp_dec
    |=> $stable(power_control_reg) && $stable(cfg_reg) && $stable(sp_reg))
    else $error("bit write reached a byte-only register");
  a_xram_gate: assert property (o_xram_move_enable == |cfg_reg[1:0])
    else $error("extended RAM move enable does not match its field");
  a_carrier_gate: assert property (o_carrier_pin_select == (cfg_reg[4] ? ext_port_config_reg : 8'h00))
    else $error("carrier pins not gated by the carrier enable");

endmodule : mcu_core_sfr_bank

//--- verification/tb_mcu_core_sfr_bank.sv
// self-checking testbench for the core special-function register bank
`timescale 1ns/1ps
module tb_mcu_core_sfr_bank;
  // ----------------------------------------------------------------
  // stimulus signals
  // ----------------------------------------------------------------
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] i_bit_addr = 8'h00;
  logic i_bit_wr = 1'b0;
  logic i_bit_rd = 1'b0;
  logic i_bit_wdata = 1'b0;
  mcu_sfr_pkg::alu_op_t i_alu_op = mcu_sfr_pkg::ALU_NONE;
  logic i_alu_carry = 1'b0;
  logic i_alu_half_carry = 1'b0;
  logic i_alu_overflow = 1'b0;
  logic i_acc_load = 1'b0;
  logic [7:0] i_acc_data = 8'h00;
  logic i_b_load = 1'b0;
  logic [7:0] i_b_data = 8'h00;
  logic i_pointer_pair_load = 1'b0;
  logic [15:0] i_pointer_pair_data = 16'h0000;
  logic i_pointer_pair_inc = 1'b0;
  logic i_sp_inc = 1'b0;
  logic i_sp_dec = 1'b0;
  logic [7:0] o_sfr_rdata, o_acc, o_b, o_psw, o_sp, o_carrier_pin_select;
  logic o_sfr_hit, o_bit_rdata, o_bit_hit, o_baud_doubler, o_uart_error_check_enable;
  logic o_sync_port_select, o_xram_move_enable;
  logic [15:0] o_pointer_pair;
  logic [4:0] o_bank_base;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] v;
  logic [7:0] exp_f;

  always #25 i_ref_clk = ~i_ref_clk;

  mcu_core_sfr_bank mcu_core_sfr_bank_i (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata), .i_bit_addr(i_bit_addr), .i_bit_wr(i_bit_wr),
    .i_bit_rd(i_bit_rd), .i_bit_wdata(i_bit_wdata), .i_alu_op(i_alu_op),
    .i_alu_carry(i_alu_carry), .i_alu_half_carry(i_alu_half_carry),
    .i_alu_overflow(i_alu_overflow), .i_acc_load(i_acc_load), .i_acc_data(i_acc_data),
    .i_b_load(i_b_load), .i_b_data(i_b_data), .i_pointer_pair_load(i_pointer_pair_load),
    .i_pointer_pair_data(i_pointer_pair_data), .i_pointer_pair_inc(i_pointer_pair_inc), .i_sp_inc(i_sp_inc),
    .i_sp_dec(i_sp_dec), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
    .o_bit_rdata(o_bit_rdata), .o_bit_hit(o_bit_hit), .o_acc(o_acc), .o_b(o_b),
    .o_psw(o_psw), .o_pointer_pair(o_pointer_pair), .o_sp(o_sp), .o_bank_base(o_bank_base),
    .o_baud_doubler(o_baud_doubler), .o_uart_error_check_enable(o_uart_error_check_enable),
    .o_sync_port_select(o_sync_port_select), .o_carrier_pin_select(o_carrier_pin_select),
    .o_xram_move_enable(o_xram_move_enable)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // every request is held across exactly one taking edge, then dropped at that edge
  task automatic end_cycle();
    @(posedge i_ref_clk);
    i_sfr_wr <= 1'b0;
    i_sfr_rd <= 1'b0;
    i_bit_wr <= 1'b0;
    i_bit_rd <= 1'b0;
    i_acc_load <= 1'b0;
    i_b_load <= 1'b0;
    i_pointer_pair_load <= 1'b0;
    i_pointer_pair_inc <= 1'b0;
    i_sp_inc <= 1'b0;
    i_sp_dec <= 1'b0;
    i_alu_op <= mcu_sfr_pkg::ALU_NONE;
    #1;
  endtask : end_cycle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    end_cycle();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    end_cycle();
    check({o_sfr_hit, o_sfr_rdata}, {h, d});
  endtask : rd

  task automatic bit_wr(input logic [7:0] a, input logic d);
    @(posedge i_ref_clk);
    i_bit_addr <= a;
    i_bit_wdata <= d;
    i_bit_wr <= 1'b1;
    end_cycle();
  endtask : bit_wr

  task automatic bit_rd(input logic [7:0] a, input logic h, input logic d);
    @(posedge i_ref_clk);
    i_bit_addr <= a;
    i_bit_rd <= 1'b1;
    end_cycle();
    check({o_bit_hit, o_bit_rdata}, {h, d});
  endtask : bit_rd

  task automatic alu(input int op, input logic c, input logic h, input logic o);
    @(posedge i_ref_clk);
    i_alu_op <= mcu_sfr_pkg::alu_op_t'(op[2:0]);
    i_alu_carry <= c;
    i_alu_half_carry <= h;
    i_alu_overflow <= o;
    end_cycle();
  endtask : alu

  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] ra [9] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'haf, 8'hd0, 8'he0, 8'hf0, 8'h9f};
    logic [7:0] rv [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    #1;
    check({o_xram_move_enable, o_baud_doubler, o_pointer_pair}, 18'h2_0000);
    for (int k = 0; k < 9; k++) rd(ra[k], 1'b1, rv[k]);
    rd(8'h90, 1'b0, 8'h00);
    // pointer bytes, whole load and carry into the high byte
    // back-to-back byte writes, low then high
    @(posedge i_ref_clk);
    i_sfr_addr <= 8'h82;
    i_sfr_wdata <= 8'h34;
    i_sfr_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_sfr_addr <= 8'h83;
    i_sfr_wdata <= 8'h12;
    end_cycle();
    check(o_pointer_pair, 16'h1234);
    rd(8'h83, 1'b1, 8'h12);
    wr(8'h82, 8'hff);
    @(posedge i_ref_clk);
    i_pointer_pair_inc <= 1'b1;
    end_cycle();
    check(o_pointer_pair, 16'h1300);
    @(posedge i_ref_clk);
    i_pointer_pair_data <= 16'habcd;
    i_pointer_pair_load <= 1'b1;
    end_cycle();
    rd(8'h82, 1'b1, 8'hcd);
    // stack pointer wraps on eight bits both ways
    wr(8'h81, 8'hff);
    @(posedge i_ref_clk);
    i_sp_inc <= 1'b1;
    end_cycle();
    check(o_sp, 8'h00);
    @(posedge i_ref_clk);
    i_sp_dec <= 1'b1;
    end_cycle();
    rd(8'h81, 1'b1, 8'hff);
    // a frozen clock enable must block a write
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    wr(8'h81, 8'h55);
    i_clk_en <= 1'b1;
    check(o_sp, 8'hff);
    // power and configuration fields
    wr(8'h87, 8'h80);
    check(o_baud_doubler, 1'b1);
    wr(8'h87, 8'h00);
    check(o_baud_doubler, 1'b0);
    rd(8'h87, 1'b1, 8'h00);
    wr(8'haf, 8'hc0);
    check({o_uart_error_check_enable, o_sync_port_select}, 2'b10);
    wr(8'haf, 8'ha0);
    check({o_uart_error_check_enable, o_sync_port_select}, 2'b01);
    wr(8'h9f, 8'ha5);
    check(o_carrier_pin_select, 8'h00);
    wr(8'haf, 8'h90);
    check(o_carrier_pin_select, 8'ha5);
    for (int k = 0; k < 4; k++) begin
      wr(8'haf, 8'h80 | k[7:0]);
      check(o_xram_move_enable, k != 0);
    end
    rd(8'haf, 1'b1, 8'h83);
    bit_wr(8'hac, 1'b1);
    rd(8'haf, 1'b1, 8'h83);
    bit_rd(8'h80, 1'b0, 1'b0);
    // parity follows every working-register value
    for (int k = 0; k < 8; k++) begin
      v = 8'(k * 37 + 1);
      @(posedge i_ref_clk);
      i_acc_data <= v;
      i_acc_load <= 1'b1;
      end_cycle();
      check({o_acc, o_psw[0]}, {v, ^v});
    end
    bit_wr(8'he2, ~v[2]);
    v[2] = ~v[2];
    check({o_acc, o_psw[0]}, {v, ^v});
    wr(8'hd0, 8'hff);
    check(o_psw, {7'h7f, ^v});
    // bank select and bank base
    for (int k = 0; k < 4; k++) begin
      wr(8'hd0, 8'(k << 3));
      check({o_psw[4:3], o_bank_base}, {k[1:0], 5'(k * 8)});
    end
    // flags updated per operation code, user flags left alone
    for (int k = 0; k < 8; k++) begin
      wr(8'hd0, 8'h00);
      alu(k, 1'b1, 1'b1, 1'b1);
      exp_f = 8'h00;
      if (k >= 1 && k <= 5) exp_f = 8'h84;
      if (k == 1 || k == 2) exp_f = 8'hc4;
      check(o_psw & 8'hc4, exp_f);
    end
    wr(8'hd0, 8'h22);
    alu(1, 1'b1, 1'b1, 1'b1);
    check(o_psw & 8'he6, 8'he6);
    alu(3, 1'b0, 1'b0, 1'b0);
    check(o_psw & 8'he6, 8'h62);
    bit_wr(8'hd5, 1'b0);
    bit_rd(8'hd5, 1'b1, 1'b0);
    bit_rd(8'hd6, 1'b1, 1'b1);
    // helper register by load and by bit
    @(posedge i_ref_clk);
    i_b_data <= 8'h5a;
    i_b_load <= 1'b1;
    end_cycle();
    bit_wr(8'hf7, 1'b1);
    rd(8'hf0, 1'b1, 8'hda);
    check(o_b, 8'hda);
    test_done();
  end
endmodule : tb_mcu_core_sfr_bank
